// ### sfr_readout.sv
`timescale 1ns/1ps
`include "sfr_params.svh"

// Summary of operation
// - tagged 14-bit word: tag in bits 15:14, sample in 13:0
// - tagged 12-bit word: tag, two sign bits, 12-bit sample in 11:0
// - 8-bit packed: upper eight sample bits only, untagged
// - 8-bit packed: first sample is byte 0, next is byte 1
// - 12-bit packed: two samples in three bytes, low nibble order as shown
// - queue holds 513 entries: 512 memory words plus a holding register
// - entries form repeating sets, one sample per selected measurement
// - four-bit channel select chooses set contents, 11xx unused
// - temperature or converter stored only when its own enable is set
// - each source maps to either pin; pin level is OR of mapped sources
// - pin with nothing mapped floats; both float during reset
// - pins active high unless the mapping polarity bit selects active low
// - reading the flag register clears activity and inactivity flags
// - reading any output data register clears data ready
// - queue flags drop only once reads or disabling the queue remove their condition
// - mode selects disabled, oldest saved, stream or triggered behaviour
// - watermark flag while count is at or above the programmed level
// - overrun on lost sample or stream-mode displacement, not pre-trigger displacement; cleared by reading or disable
// - ready flag while at least one sample waits at the output
module sfr_readout
	import sfr_pkg::*;
#(
	parameter int DEPTH = `SFR_MEM_DEPTH
) (
	input  wire logic       sys_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       link_clk_i,
	input  wire logic       smp_stb_i,
	input  sfr_set_s        smp_set_i,
	input  wire logic       act_evt_i,
	input  wire logic       inact_evt_i,
	input  wire logic       adc_evt_i,
	input  wire logic       lk_req_i,
	input  sfr_req_s        lk_cmd_i,
	output logic            lk_busy_o,
	output logic            lk_rvalid_o,
	output logic [7:0]      lk_rdata_o,
	output logic [1:0]      irq_pin_o,
	output logic [1:0]      irq_pin_oe_o
);
	localparam int CW  = $clog2(DEPTH + 2);
	localparam int RQW = $bits(sfr_req_s);
	localparam logic [CW-1:0] CAP = CW'(DEPTH + 1);
	localparam int WW  = CW > 9 ? CW : 9;

	// ==========================================
	// link domain
	logic           busy_r, busy_nxt;
	logic           lk_send;
	logic [RQW-1:0] req_raw;
	sfr_req_s       req;
	logic           req_stb;
	logic [7:0]     rsp_byte;

	assign lk_send = lk_req_i & ~busy_r;

	always_comb
	begin
		busy_nxt = busy_r;
		if (lk_send)
			busy_nxt = 1'b1;
		if (lk_rvalid_o)
			busy_nxt = 1'b0;
	end

	always_ff @(posedge link_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			busy_r <= 1'b0;
		else
			busy_r <= busy_nxt;
	end

	assign lk_busy_o = busy_r;

	sfr_xfer #(.W(RQW)) u_req (
		.src_clk_i  (link_clk_i),
		.dst_clk_i  (sys_clk_i),
		.resetn_i   (resetn_i),
		.src_stb_i  (lk_send),
		.src_data_i (lk_cmd_i),
		.dst_stb_o  (req_stb),
		.dst_data_o (req_raw)
	);

	sfr_xfer #(.W(8)) u_rsp (
		.src_clk_i  (sys_clk_i),
		.dst_clk_i  (link_clk_i),
		.resetn_i   (resetn_i),
		.src_stb_i  (req_stb),
		.src_data_i (rsp_byte),
		.dst_stb_o  (lk_rvalid_o),
		.dst_data_o (lk_rdata_o)
	);

	assign req = sfr_req_s'(req_raw);

	// ==========================================
	// configuration registers
	logic [7:0] qctl_r, qctl_nxt, qsmp_r, qsmp_nxt, qfmt_r, qfmt_nxt;
	logic [7:0] therm_r, therm_nxt, conv_r, conv_nxt;
	logic [7:0] mlo_r [2];
	logic [7:0] mlo_nxt [2];
	logic [7:0] mhi_r [2];
	logic [7:0] mhi_nxt [2];
	logic       wr;

	assign wr = req_stb && req.op == SFR_OP_WR;

	always_comb
	begin
		qctl_nxt  = qctl_r;
		qsmp_nxt  = qsmp_r;
		qfmt_nxt  = qfmt_r;
		therm_nxt = therm_r;
		conv_nxt  = conv_r;
		mlo_nxt   = mlo_r;
		mhi_nxt   = mhi_r;
		if (wr)
		begin
			case (req.addr)
				`SFR_A_QCTL:    qctl_nxt   = req.wdata;
				`SFR_A_QSMP:    qsmp_nxt   = req.wdata;
				`SFR_A_QFMT:    qfmt_nxt   = req.wdata;
				`SFR_A_THERM:   therm_nxt  = req.wdata;
				`SFR_A_CONV:    conv_nxt   = req.wdata;
				`SFR_A_MAPA_LO: mlo_nxt[0] = req.wdata;
				`SFR_A_MAPB_LO: mlo_nxt[1] = req.wdata;
				`SFR_A_MAPA_HI: mhi_nxt[0] = req.wdata;
				`SFR_A_MAPB_HI: mhi_nxt[1] = req.wdata;
				default:        qctl_nxt   = qctl_r;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			qctl_r  <= `SFR_RST_QCTL;
			qsmp_r  <= `SFR_RST_QSMP;
			qfmt_r  <= `SFR_RST_QFMT;
			therm_r <= `SFR_RST_EN;
			conv_r  <= `SFR_RST_EN;
			mlo_r   <= '{`SFR_RST_MAP, `SFR_RST_MAP};
			mhi_r   <= '{`SFR_RST_MAP, `SFR_RST_MAP};
		end
		else
		begin
			qctl_r  <= qctl_nxt;
			qsmp_r  <= qsmp_nxt;
			qfmt_r  <= qfmt_nxt;
			therm_r <= therm_nxt;
			conv_r  <= conv_nxt;
			mlo_r   <= mlo_nxt;
			mhi_r   <= mhi_nxt;
		end
	end

	// ==========================================
	// decoded settings
	sfr_mode_e  mode;
	sfr_fmt_e   fmt;
	logic [3:0] sel, mask;
	logic [2:0] axes;
	logic [8:0] wm_lvl;
	logic       aux_en;

	assign mode   = sfr_mode_e'(qctl_r[`SFR_QCTL_MODE_LSB +: 2]);
	assign fmt    = sfr_fmt_e'(qfmt_r[`SFR_QFMT_FMT_LSB +: 2]);
	assign sel    = qfmt_r[`SFR_QFMT_CH_LSB +: 4];
	assign wm_lvl = {qctl_r[`SFR_QCTL_SMP8], qsmp_r};
	assign aux_en = sel[3] ? conv_r[`SFR_EN_BIT] : therm_r[`SFR_EN_BIT];

	always_comb
	begin
		case (sel[1:0])
			2'h1:    axes = 3'b001;
			2'h2:    axes = 3'b010;
			2'h3:    axes = 3'b100;
			default: axes = 3'b111;
		endcase
		mask = {(sel[3] | sel[2]) & aux_en, axes};
		if (sel[3:2] == 2'b11)
			mask = 4'h0;
	end

	// ==========================================
	// set sequencer
	sfr_state_e st_r, st_nxt;
	logic [3:0] pend_r, pend_nxt;
	sfr_set_s   set_r, set_nxt, lat_r, lat_nxt;
	logic [1:0] ch;
	logic [15:0] entry;
	logic       push_want;

	always_comb
	begin
		ch = 2'd3;
		if (pend_r[2])
			ch = 2'd2;
		if (pend_r[1])
			ch = 2'd1;
		if (pend_r[0])
			ch = 2'd0;
		case (ch)
			2'd0:    entry = {`SFR_TAG_X, set_r.x};
			2'd1:    entry = {`SFR_TAG_Y, set_r.y};
			2'd2:    entry = {`SFR_TAG_Z, set_r.z};
			default: entry = {`SFR_TAG_AUX, sel[3] ? set_r.adc : set_r.temp};
		endcase
	end

	assign push_want = st_r == SFR_ST_PUSH;

	always_comb
	begin
		st_nxt   = st_r;
		pend_nxt = pend_r;
		set_nxt  = set_r;
		lat_nxt  = smp_stb_i ? smp_set_i : lat_r;
		case (st_r)
			SFR_ST_IDLE:
			begin
				if (smp_stb_i && mode != SFR_MODE_OFF && mask != 4'h0)
				begin
					set_nxt  = smp_set_i;
					pend_nxt = mask;
					st_nxt   = SFR_ST_PUSH;
				end
			end
			SFR_ST_PUSH:
			begin
				pend_nxt[ch] = 1'b0;
				if (pend_nxt == 4'h0 || mode == SFR_MODE_OFF)
					st_nxt = SFR_ST_IDLE;
			end
			default: st_nxt = SFR_ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_r   <= SFR_ST_IDLE;
			pend_r <= 4'h0;
			set_r  <= '0;
			lat_r  <= '0;
		end
		else
		begin
			st_r   <= st_nxt;
			pend_r <= pend_nxt;
			set_r  <= set_nxt;
			lat_r  <= lat_nxt;
		end
	end

	// ==========================================
	// queue and fill policy
	logic [15:0]   head;
	logic [CW-1:0] count;
	logic          trig_r, pre, cap_hit, drop, lost, q_push, q_pop, rd_pop;

	assign pre     = mode == SFR_MODE_TRIG && !trig_r;
	assign cap_hit = pre ? (count != '0 && WW'(count) >= WW'(wm_lvl)) : count == CAP;
	assign drop    = push_want && cap_hit && !rd_pop && (mode == SFR_MODE_STREAM || pre);
	assign lost    = push_want && cap_hit && !rd_pop && !pre;
	assign q_push  = push_want && (!cap_hit || rd_pop || drop);
	assign q_pop   = rd_pop | drop;

	sfr_queue #(.W(16), .DEPTH(DEPTH), .CW(CW)) u_queue (
		.clk_i    (sys_clk_i),
		.resetn_i (resetn_i),
		.clear_i  (mode == SFR_MODE_OFF),
		.push_i   (q_push),
		.data_i   (entry),
		.pop_i    (q_pop),
		.head_o   (head),
		.count_o  (count)
	);

	// ==========================================
	// queue byte readout
	logic [1:0]  ph_r, ph_nxt;
	logic [3:0]  nib_r, nib_nxt;
	logic [7:0]  pkb_r, pkb_nxt;
	logic [15:0] word;
	logic [11:0] s12;
	logic [7:0]  q_byte;
	logic        q_rd, avail;
	sfr_fmt_e    fmt_r;

	assign q_rd  = req_stb && req.op == SFR_OP_QRD;
	assign avail = count != '0;
	assign s12   = head[13:2];

	always_comb
	begin
		word    = head;
		if (fmt == SFR_FMT_T12)
			word = {head[15:14], {2{head[13]}}, s12};
		ph_nxt  = (fmt != fmt_r || mode == SFR_MODE_OFF) ? 2'd0 : ph_r;
		nib_nxt = nib_r;
		pkb_nxt = pkb_r;
		q_byte  = 8'h00;
		rd_pop  = 1'b0;
		if (q_rd)
		begin
			case (fmt)
				SFR_FMT_P8:
				begin
					q_byte = avail ? head[13:6] : 8'h00;
					rd_pop = avail;
				end
				SFR_FMT_P12:
				begin
					case (ph_r)
						2'd0:
						begin
							q_byte  = avail ? s12[7:0] : 8'h00;
							nib_nxt = s12[11:8];
							rd_pop  = avail;
							ph_nxt  = avail ? 2'd1 : 2'd0;
						end
						2'd1:
						begin
							q_byte  = {avail ? s12[3:0] : 4'h0, nib_r};
							pkb_nxt = s12[11:4];
							rd_pop  = avail;
							ph_nxt  = avail ? 2'd2 : 2'd0;
						end
						default:
						begin
							q_byte = pkb_r;
							ph_nxt = 2'd0;
						end
					endcase
				end
				default:
				begin
					q_byte = ph_r[0] ? word[15:8] : word[7:0];
					rd_pop = avail && ph_r[0];
					ph_nxt = avail ? {1'b0, ~ph_r[0]} : 2'd0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ph_r  <= 2'd0;
			nib_r <= 4'h0;
			pkb_r <= 8'h00;
			fmt_r <= SFR_FMT_T14;
		end
		else
		begin
			ph_r  <= ph_nxt;
			nib_r <= nib_nxt;
			pkb_r <= pkb_nxt;
			fmt_r <= fmt;
		end
	end

	// ==========================================
	// event flags
	logic ovr_r, ovr_nxt, drdy_r, drdy_nxt, act_r, act_nxt;
	logic inact_r, inact_nxt, adc_r, adc_nxt, trig_nxt;
	logic rd_stat, rd_data;
	logic [7:0] status;

	assign rd_stat = req_stb && req.op == SFR_OP_RD && req.addr == `SFR_A_STATUS;
	assign rd_data = req_stb && req.op == SFR_OP_RD
		&& ((req.addr >= `SFR_A_DAT8_LO && req.addr <= `SFR_A_DAT8_HI)
		|| (req.addr >= `SFR_A_DAT16_LO && req.addr <= `SFR_A_DAT16_HI));

	always_comb
	begin
		ovr_nxt   = (rd_pop || mode == SFR_MODE_OFF) ? 1'b0 : ovr_r;
		ovr_nxt   = ovr_nxt | lost;
		drdy_nxt  = (drdy_r & ~rd_data) | smp_stb_i;
		act_nxt   = (act_r & ~rd_stat) | act_evt_i;
		inact_nxt = (inact_r & ~rd_stat) | inact_evt_i;
		adc_nxt   = (adc_r & ~rd_stat) | adc_evt_i;
		trig_nxt  = mode == SFR_MODE_TRIG && (trig_r | act_evt_i);
		status    = 8'h00;
		status[`SFR_ST_DRDY]  = drdy_r;
		status[`SFR_ST_FRDY]  = avail;
		status[`SFR_ST_WM]    = WW'(count) >= WW'(wm_lvl);
		status[`SFR_ST_OVR]   = ovr_r;
		status[`SFR_ST_ACT]   = act_r;
		status[`SFR_ST_INACT] = inact_r;
		status[`SFR_ST_ADC]   = adc_r;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ovr_r   <= 1'b0;
			drdy_r  <= 1'b0;
			act_r   <= 1'b0;
			inact_r <= 1'b0;
			adc_r   <= 1'b0;
			trig_r  <= 1'b0;
		end
		else
		begin
			ovr_r   <= ovr_nxt;
			drdy_r  <= drdy_nxt;
			act_r   <= act_nxt;
			inact_r <= inact_nxt;
			adc_r   <= adc_nxt;
			trig_r  <= trig_nxt;
		end
	end

	// ==========================================
	// register read answer
	function automatic logic [7:0] hi_b(input logic [13:0] v);
		hi_b = v[13:6];
	endfunction

	function automatic logic [7:0] lo_b(input logic [13:0] v);
		lo_b = {v[5:0], 2'b00};
	endfunction

	always_comb
	begin
		rsp_byte = 8'h00;
		if (q_rd)
			rsp_byte = q_byte;
		else if (req.op == SFR_OP_RD)
		begin
			case (req.addr)
				8'h08:          rsp_byte = hi_b(lat_r.x);
				8'h09:          rsp_byte = hi_b(lat_r.y);
				8'h0A:          rsp_byte = hi_b(lat_r.z);
				`SFR_A_STATUS:  rsp_byte = status;
				8'h0E:          rsp_byte = hi_b(lat_r.x);
				8'h0F:          rsp_byte = lo_b(lat_r.x);
				8'h10:          rsp_byte = hi_b(lat_r.y);
				8'h11:          rsp_byte = lo_b(lat_r.y);
				8'h12:          rsp_byte = hi_b(lat_r.z);
				8'h13:          rsp_byte = lo_b(lat_r.z);
				8'h14:          rsp_byte = hi_b(lat_r.temp);
				8'h15:          rsp_byte = lo_b(lat_r.temp);
				`SFR_A_QCTL:    rsp_byte = qctl_r;
				`SFR_A_QSMP:    rsp_byte = qsmp_r;
				`SFR_A_QFMT:    rsp_byte = qfmt_r;
				`SFR_A_THERM:   rsp_byte = therm_r;
				`SFR_A_CONV:    rsp_byte = conv_r;
				`SFR_A_MAPA_LO: rsp_byte = mlo_r[0];
				`SFR_A_MAPB_LO: rsp_byte = mlo_r[1];
				`SFR_A_MAPA_HI: rsp_byte = mhi_r[0];
				`SFR_A_MAPB_HI: rsp_byte = mhi_r[1];
				default:        rsp_byte = 8'h00;
			endcase
		end
	end

	// ==========================================
	// interrupt pins
	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++)
		begin : g_pin
			logic lvl_nxt, oe_nxt, hit;

			always_comb
			begin
				hit = |(status[5:0] & mlo_r[gp][5:0])
					| (adc_r & mhi_r[gp][`SFR_MAPH_ADC_BIT]);
				lvl_nxt = hit ^ mlo_r[gp][`SFR_MAP_LOW_BIT];
				oe_nxt  = |mlo_r[gp][5:0] | mhi_r[gp][`SFR_MAPH_ADC_BIT];
			end

			always_ff @(posedge sys_clk_i or negedge resetn_i)
			begin
				if (!resetn_i)
				begin
					irq_pin_o[gp]    <= 1'b0;
					irq_pin_oe_o[gp] <= 1'b0;
				end
				else
				begin
					irq_pin_o[gp]    <= lvl_nxt;
					irq_pin_oe_o[gp] <= oe_nxt;
				end
			end
		end
	endgenerate
endmodule

// ### sfr_params.svh
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH

// ==========================================
// register offsets
`define SFR_A_DAT8_LO   8'h08
`define SFR_A_DAT8_HI   8'h0A
`define SFR_A_STATUS    8'h0B
`define SFR_A_DAT16_LO  8'h0E
`define SFR_A_DAT16_HI  8'h15
`define SFR_A_QCTL      8'h28
`define SFR_A_QSMP      8'h29
`define SFR_A_MAPA_LO   8'h2A
`define SFR_A_MAPB_LO   8'h2B
`define SFR_A_MAPA_HI   8'h3A
`define SFR_A_MAPB_HI   8'h3B
`define SFR_A_QFMT      8'h3C
`define SFR_A_THERM     8'h4A
`define SFR_A_CONV      8'h4B

// ==========================================
// field positions
`define SFR_QCTL_MODE_LSB 0
`define SFR_QCTL_SMP8     2
`define SFR_QFMT_CH_LSB   0
`define SFR_QFMT_FMT_LSB  4
`define SFR_EN_BIT        0
`define SFR_MAP_LOW_BIT   7
`define SFR_MAPH_ADC_BIT  0
`define SFR_ST_DRDY       0
`define SFR_ST_FRDY       1
`define SFR_ST_WM         2
`define SFR_ST_OVR        3
`define SFR_ST_ACT        4
`define SFR_ST_INACT      5
`define SFR_ST_ADC        6

// ==========================================
// reset values and sizes
`define SFR_RST_QCTL    8'h00
`define SFR_RST_QSMP    8'h80
`define SFR_RST_QFMT    8'h00
`define SFR_RST_MAP     8'h00
`define SFR_RST_EN      8'h00
`define SFR_MEM_DEPTH   512
`define SFR_TAG_X       2'b00
`define SFR_TAG_Y       2'b01
`define SFR_TAG_Z       2'b10
`define SFR_TAG_AUX     2'b11

`endif

// ### sfr_pkg.sv
package sfr_pkg;

	typedef enum logic [1:0] {
		SFR_OP_NONE = 2'h0,
		SFR_OP_RD   = 2'h1,
		SFR_OP_WR   = 2'h2,
		SFR_OP_QRD  = 2'h3
	} sfr_op_e;

	typedef enum logic [1:0] {
		SFR_MODE_OFF    = 2'h0,
		SFR_MODE_OLD    = 2'h1,
		SFR_MODE_STREAM = 2'h2,
		SFR_MODE_TRIG   = 2'h3
	} sfr_mode_e;

	typedef enum logic [1:0] {
		SFR_FMT_T14 = 2'h0,
		SFR_FMT_T12 = 2'h1,
		SFR_FMT_P8  = 2'h2,
		SFR_FMT_P12 = 2'h3
	} sfr_fmt_e;

	typedef enum logic {
		SFR_ST_IDLE = 1'b0,
		SFR_ST_PUSH = 1'b1
	} sfr_state_e;

	typedef struct packed {
		sfr_op_e    op;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;

	typedef struct packed {
		logic [13:0] x;
		logic [13:0] y;
		logic [13:0] z;
		logic [13:0] temp;
		logic [13:0] adc;
	} sfr_set_s;

endpackage

// ### sfr_xfer.sv
`timescale 1ns/1ps
// toggle handshake word crossing
module sfr_xfer #(
	parameter int W = 8
) (
	input  wire logic         src_clk_i,
	input  wire logic         dst_clk_i,
	input  wire logic         resetn_i,
	input  wire logic         src_stb_i,
	input  wire logic [W-1:0] src_data_i,
	output logic              dst_stb_o,
	output logic [W-1:0]      dst_data_o
);
	logic         tog_r,  tog_nxt;
	logic [W-1:0] hold_r, hold_nxt;
	logic         s1_r, s2_r, s3_r;
	logic         stb_nxt;
	logic [W-1:0] data_nxt;

	// ==========================================
	// source side
	always_comb
	begin
		tog_nxt  = tog_r ^ src_stb_i;
		hold_nxt = src_stb_i ? src_data_i : hold_r;
	end

	always_ff @(posedge src_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tog_r  <= 1'b0;
			hold_r <= '0;
		end
		else
		begin
			tog_r  <= tog_nxt;
			hold_r <= hold_nxt;
		end
	end

	// ==========================================
	// destination side
	always_comb
	begin
		stb_nxt  = s2_r ^ s3_r;
		data_nxt = stb_nxt ? hold_r : dst_data_o;
	end

	always_ff @(posedge dst_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s1_r       <= 1'b0;
			s2_r       <= 1'b0;
			s3_r       <= 1'b0;
			dst_stb_o  <= 1'b0;
			dst_data_o <= '0;
		end
		else
		begin
			s1_r       <= tog_r;
			s2_r       <= s1_r;
			s3_r       <= s2_r;
			dst_stb_o  <= stb_nxt;
			dst_data_o <= data_nxt;
		end
	end
endmodule

// ### sfr_queue.sv
`timescale 1ns/1ps
// memory ring plus one holding register at the head
module sfr_queue #(
	parameter int W     = 16,
	parameter int DEPTH = 512,
	parameter int CW    = 10
) (
	input  wire logic          clk_i,
	input  wire logic          resetn_i,
	input  wire logic          clear_i,
	input  wire logic          push_i,
	input  wire logic [W-1:0]  data_i,
	input  wire logic          pop_i,
	output logic [W-1:0]       head_o,
	output logic [CW-1:0]      count_o
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]   mc_r, mc_nxt;
	logic          hv_r, hv_nxt, we;
	logic [W-1:0]  hd_r, hd_nxt;

	always_comb
	begin
		hv_nxt = hv_r & ~pop_i;
		hd_nxt = hd_r;
		rp_nxt = rp_r;
		wp_nxt = wp_r;
		mc_nxt = mc_r;
		we     = 1'b0;
		if (!hv_nxt && mc_r != '0)
		begin
			hd_nxt = mem[rp_r];
			hv_nxt = 1'b1;
			rp_nxt = AW'(rp_r + 1'b1);
			mc_nxt = (AW+1)'(mc_r - 1'b1);
		end
		if (push_i)
		begin
			if (!hv_nxt)
			begin
				hd_nxt = data_i;
				hv_nxt = 1'b1;
			end
			else
			begin
				we     = 1'b1;
				wp_nxt = AW'(wp_r + 1'b1);
				mc_nxt = (AW+1)'(mc_nxt + 1'b1);
			end
		end
		if (clear_i)
		begin
			hv_nxt = 1'b0;
			rp_nxt = '0;
			wp_nxt = '0;
			mc_nxt = '0;
			we     = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (we)
			mem[wp_r] <= data_i;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			hv_r <= 1'b0;
			hd_r <= '0;
			rp_r <= '0;
			wp_r <= '0;
			mc_r <= '0;
		end
		else
		begin
			hv_r <= hv_nxt;
			hd_r <= hd_nxt;
			rp_r <= rp_nxt;
			wp_r <= wp_nxt;
			mc_r <= mc_nxt;
		end
	end

	assign head_o  = hd_r;
	assign count_o = CW'(mc_r) + CW'(hv_r);
endmodule

// ### sfr_readout_asserts.sv
`timescale 1ns/1ps
module sfr_readout_asserts (
	input wire logic       sys_clk_i,
	input wire logic       resetn_i,
	input wire logic       link_clk_i,
	input wire logic       lk_req_i,
	input wire logic       lk_busy_o,
	input wire logic       lk_rvalid_o,
	input wire logic [7:0] lk_rdata_o,
	input wire logic [1:0] irq_pin_o,
	input wire logic [1:0] irq_pin_oe_o
);
	// ========
	// link handshake
	sequence s_take;
		lk_req_i && !lk_busy_o;
	endsequence
	sequence s_answer;
		##[3:16] lk_rvalid_o;
	endsequence
	property p_answer;
		@(posedge link_clk_i) disable iff (!resetn_i) s_take |-> s_answer;
	endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	property p_busy_set;
		@(posedge link_clk_i) disable iff (!resetn_i) s_take |=> lk_busy_o;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy missing after request");
	property p_busy_hold;
		@(posedge link_clk_i) disable iff (!resetn_i) lk_busy_o && !lk_rvalid_o |=> lk_busy_o;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
	property p_busy_drop;
		@(posedge link_clk_i) disable iff (!resetn_i) lk_rvalid_o |=> !lk_busy_o && !lk_rvalid_o;
	endproperty
	a_busy_drop: assert property (p_busy_drop) else $error("answer not closed");
	property p_rv_busy;
		@(posedge link_clk_i) disable iff (!resetn_i) lk_rvalid_o |-> lk_busy_o;
	endproperty
	a_rv_busy: assert property (p_rv_busy) else $error("answer without request");
	property p_rdata_hold;
		@(posedge link_clk_i) disable iff (!resetn_i) !lk_rvalid_o |-> $stable(lk_rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("answer byte moved");
	// ========
	// interrupt pins
	property p_pin_rst;
		@(posedge sys_clk_i) !resetn_i |-> irq_pin_oe_o == 2'b00 && irq_pin_o == 2'b00;
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("pins driven in reset");
	property p_pin_rise;
		@(posedge sys_clk_i) disable iff (!resetn_i) $rose(resetn_i) |-> (irq_pin_oe_o == 2'b00) [*8];
	endproperty
	a_pin_rise: assert property (p_pin_rise) else $error("pins driven with no map");
endmodule

bind sfr_readout sfr_readout_asserts u_sfr_readout_asserts (.sys_clk_i, .resetn_i, .link_clk_i,
	.lk_req_i, .lk_busy_o, .lk_rvalid_o, .lk_rdata_o, .irq_pin_o, .irq_pin_oe_o);

// ### sfr_host.sv
`timescale 1ns/1ps
module sfr_host
	import sfr_pkg::*;
(
	input  wire logic       link_clk_i,
	input  wire logic       lk_busy_i,
	input  wire logic       lk_rvalid_i,
	input  wire logic [7:0] lk_rdata_i,
	output logic            lk_req_o,
	output sfr_req_s        lk_cmd_o
);
	int n = 0;
	int tmo = 0;
	initial
	begin
		lk_req_o = 1'b0;
		lk_cmd_o = '0;
	end
	// ========
	// one request strobe, command held until answered
	task automatic xact(input sfr_op_e op, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		int t;
		t = 0;
		repeat (n % 3) @(negedge link_clk_i);
		n++;
		@(negedge link_clk_i);
		while (lk_busy_i === 1'b1)
			@(negedge link_clk_i);
		lk_req_o = 1'b1;
		lk_cmd_o = '{op, a, d};
		@(negedge link_clk_i);
		lk_req_o = 1'b0;
		while (lk_rvalid_i !== 1'b1 && t < 40)
		begin
			@(negedge link_clk_i);
			t++;
		end
		if (t >= 40)
			tmo++;
		r = lk_rdata_i;
		@(negedge link_clk_i);
		lk_cmd_o = ~lk_cmd_o;
	endtask
endmodule

// ### sfr_readout_test.sv
`timescale 1ns/1ps
`include "sfr_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("Error at %0t got %h expected %h", $time, a, b); end end
module sfr_readout_test;
	import sfr_pkg::*;
	localparam int DEPTH = 8;
	logic        sys_clk_i, link_clk_i, resetn_i, smp_stb_i, act_evt_i, inact_evt_i, adc_evt_i;
	logic        lk_req_i, lk_busy_o, lk_rvalid_o;
	sfr_set_s    smp_set_i, cur;
	sfr_req_s    lk_cmd_i;
	logic [7:0]  lk_rdata_o, rd;
	logic [1:0]  irq_pin_o, irq_pin_oe_o;
	logic [15:0] q[$];
	logic [1:0]  en = 2'b11;
	integer      errors = 0, check_count = 0, seed = 32'h55fc;

	sfr_readout #(.DEPTH(DEPTH)) u_sfr_readout (.sys_clk_i, .resetn_i, .link_clk_i, .smp_stb_i,
		.smp_set_i, .act_evt_i, .inact_evt_i, .adc_evt_i, .lk_req_i, .lk_cmd_i, .lk_busy_o,
		.lk_rvalid_o, .lk_rdata_o, .irq_pin_o, .irq_pin_oe_o);
	sfr_host u_sfr_host (.link_clk_i, .lk_busy_i(lk_busy_o), .lk_rvalid_i(lk_rvalid_o),
		.lk_rdata_i(lk_rdata_o), .lk_req_o(lk_req_i), .lk_cmd_o(lk_cmd_i));

	initial
	begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	initial
	begin
		link_clk_i = 1'b0;
		#7;
		forever #16 link_clk_i = ~link_clk_i;
	end
	initial
	begin
		#1_000_000;
		errors++;
		complete_run();
	end
	// ========
	// helpers
	task automatic complete_run();
		errors += u_sfr_host.tmo;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_sfr_host.xact(SFR_OP_WR, a, d, rd);
	endtask
	task automatic rr(input logic [7:0] a);
		u_sfr_host.xact(SFR_OP_RD, a, 8'h00, rd);
	endtask
	task automatic qr();
		u_sfr_host.xact(SFR_OP_QRD, 8'h00, 8'h00, rd);
	endtask
	task automatic settle();
		repeat (8) @(negedge sys_clk_i);
	endtask
	function automatic logic [13:0] val(input int ch, input logic [3:0] c);
		case (ch)
			0: return cur.x;
			1: return cur.y;
			2: return cur.z;
			default: return c[3] ? cur.adc : cur.temp;
		endcase
	endfunction
	function automatic bit sel(input logic [3:0] c, input int ch);
		if (c[3:2] == 2'b11)
			return 1'b0;
		if (ch == 3)
			return c[3:2] != 2'b00 && en[c[3]];
		return c[1:0] == 2'b00 || c[1:0] == ch + 1;
	endfunction
	function automatic logic [7:0] dat(input int a);
		logic [13:0] v;
		v = val(a < 14 ? a - 8 : (a - 14) / 2, 4'h0);
		return (a < 14 || a % 2 == 0) ? v[13:6] : {v[5:0], 2'b00};
	endfunction
	task automatic push_set(input logic [3:0] c);
		@(negedge sys_clk_i);
		cur = 70'({$random(seed), $random(seed), $random(seed)});
		smp_set_i = cur;
		smp_stb_i = 1'b1;
		for (int ch = 0; ch < 4; ch++)
			if (sel(c, ch))
				q.push_back({2'(ch), val(ch, c)});
		@(negedge sys_clk_i);
		smp_stb_i = 1'b0;
		repeat (6) @(negedge sys_clk_i);
	endtask
	task automatic pulse(input logic [2:0] v);
		@(negedge sys_clk_i);
		{act_evt_i, inact_evt_i, adc_evt_i} = v;
		@(negedge sys_clk_i);
		{act_evt_i, inact_evt_i, adc_evt_i} = 3'b000;
		settle();
	endtask
	task automatic drain(input logic [1:0] f, input int stop);
		logic [15:0] e, g, w;
		while (q.size() > stop)
		begin
			e = q.pop_front();
			if (f == SFR_FMT_P12)
			begin
				g = q.pop_front();
				qr();
				`CHK(rd, e[9:2])
				qr();
				`CHK(rd, {g[5:2], e[13:10]})
				qr();
				`CHK(rd, g[13:6])
			end
			else if (f == SFR_FMT_P8)
			begin
				qr();
				`CHK(rd, e[13:6])
			end
			else
			begin
				w = f[0] ? {e[15:14], {2{e[13]}}, e[13:2]} : e;
				qr();
				`CHK(rd, w[7:0])
				qr();
				`CHK(rd, w[15:8])
			end
		end
	endtask
	// ========
	// main sequence
	initial
	begin
		resetn_i = 1'b1;
		smp_stb_i = 1'b0;
		smp_set_i = '0;
		cur = '0;
		{act_evt_i, inact_evt_i, adc_evt_i} = 3'b000;
		#2 resetn_i = 1'b0;
		repeat (16) @(negedge sys_clk_i);
		resetn_i = 1'b1;
		rr(`SFR_A_STATUS);
		`CHK(rd, 8'h00)
		wr(`SFR_A_THERM, 8'h01);
		wr(`SFR_A_CONV, 8'h01);
		for (int f = 0; f < 4; f++)
			for (int c = 0; c < 16; c++)
			begin
				wr(`SFR_A_QCTL, 8'h00);
				wr(`SFR_A_QFMT, {2'b00, 2'(f), 4'(c)});
				wr(`SFR_A_QCTL, 8'h02);
				push_set(4'(c));
				push_set(4'(c));
				rr(`SFR_A_STATUS);
				`CHK(rd[2:1], {1'b0, q.size() != 0})
				drain(2'(f), 0);
				rr(`SFR_A_STATUS);
				`CHK(rd[1], 1'b0)
			end
		wr(`SFR_A_QCTL, 8'h00);
		wr(`SFR_A_QFMT, 8'h05);
		wr(`SFR_A_THERM, 8'h00);
		en[0] = 1'b0;
		wr(`SFR_A_QCTL, 8'h02);
		push_set(4'h5);
		rr(`SFR_A_STATUS);
		`CHK(rd[1], 1'b1)
		drain(2'b00, 0);
		rr(`SFR_A_STATUS);
		`CHK(rd[1], 1'b0)
		$display("format test done");
		wr(`SFR_A_QSMP, 8'h04);
		for (int m = 1; m < 4; m++)
		begin
			wr(`SFR_A_QCTL, 8'h00);
			wr(`SFR_A_QFMT, 8'h01);
			wr(`SFR_A_QCTL, 8'(m));
			repeat (DEPTH + 3) push_set(4'h1);
			if (m == 1)
				q = q[0:DEPTH];
			else if (m == 2)
				q = q[2:DEPTH + 2];
			else
				q = q[DEPTH - 1:DEPTH + 2];
			rr(`SFR_A_STATUS);
			`CHK(rd[3:1], {m != 3, 2'b11})
			drain(2'b00, 3);
			rr(`SFR_A_STATUS);
			`CHK(rd[3:2], 2'b00)
			drain(2'b00, 0);
		end
		pulse(3'b100);
		repeat (DEPTH + 3) push_set(4'h1);
		q = q[0:DEPTH];
		rr(`SFR_A_STATUS);
		`CHK(rd[4:1], 4'b1111)
		drain(2'b00, 0);
		$display("fill test done");
		wr(`SFR_A_QCTL, 8'h00);
		`CHK(irq_pin_oe_o, 2'b00)
		wr(`SFR_A_MAPA_LO, 8'h30);
		wr(`SFR_A_MAPB_LO, 8'h90);
		settle();
		`CHK({irq_pin_oe_o, irq_pin_o}, 4'b1110)
		pulse(3'b100);
		`CHK({irq_pin_oe_o, irq_pin_o}, 4'b1101)
		rr(`SFR_A_STATUS);
		`CHK(rd[5:4], 2'b01)
		settle();
		`CHK(irq_pin_o, 2'b10)
		pulse(3'b010);
		`CHK(irq_pin_o, 2'b11)
		wr(`SFR_A_MAPB_HI, 8'h01);
		pulse(3'b001);
		`CHK(irq_pin_o, 2'b01)
		rr(`SFR_A_STATUS);
		`CHK(rd[6:4], 3'b110)
		settle();
		`CHK(irq_pin_o, 2'b10)
		wr(`SFR_A_MAPA_LO, 8'h01);
		for (int a = 8; a < 22; a++)
			if (a < 11 || a > 13)
			begin
				push_set(4'h0);
				`CHK(irq_pin_o[0], 1'b1)
				rr(8'(a));
				`CHK(rd, dat(a))
				settle();
				`CHK(irq_pin_o[0], 1'b0)
			end
		q.delete();
		wr(`SFR_A_MAPA_LO, 8'h00);
		wr(`SFR_A_MAPB_LO, 8'h00);
		wr(`SFR_A_MAPB_HI, 8'h00);
		settle();
		`CHK(irq_pin_oe_o, 2'b00)
		$display("pin test done");
		complete_run();
	end
endmodule
